// ==== rtl/ccam_core.sv ====
// Command interpreter slice: conditional call stack, accumulator move and rotate
// Operation
// - Call taken: push program counter plus one, then load counter from value field.
// - Call not taken: stack untouched, continue with next command.
// - Return stack holds at most eight entries.
// - Call with full stack is ignored: no push, no jump.
// - Call opcode 21; types 0-7 test comparison result flags.
// - Call types 8-11 test timeout, alarm, deviation, position error flags.
// - Conditional call only for stored programs, not direct mode.
// - Accumulator move copies accumulator into target position.
// - Move does not block; reply at once, commands keep flowing.
// - Move opcode 46: absolute, relative, stored coordinate indexed by bank.
// - Relative move adds accumulator to actual position.
// - Position arithmetic wraps at 32 bits; shorter wrapped way taken.
// - Stop or either rotate command aborts a positioning move.
// - Ramp settings come from axis parameters, never from the frame.
// - Rotate left selects velocity mode, then accumulator to target velocity.
// - Rotate left decreases position; accumulator is microsteps per second.
// - Rotate left opcode 50; type, bank and value ignored.
// - Accepted move or rotate in direct mode replies status 100.
// - Decrement-jump decrements user variable, jumps when result nonzero.
`timescale 1ns/1ps
module ccam_core (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Frame byte stream
   input wire logic frame_valid,
   input wire logic [7:0] frame_byte,
   output logic frame_ready,
   // Program counter and reply
   output logic [31:0] pc,
   output logic reply_valid,
   output ccam_pkg::ccam_reply_t reply,
   // Interpreter state
   input wire logic signed [31:0] accum,
   input wire ccam_pkg::ccam_cmpf_t cmp_flags,
   input wire ccam_pkg::ccam_errf_t err_flags,
   input wire logic signed [31:0] actual_pos,
   // User variables and coordinates
   output logic [7:0] var_idx,
   input wire logic [31:0] var_rd,
   output logic var_wr_en,
   output logic [31:0] var_wr_data,
   output logic [7:0] stored_coordinate_target_idx,
   input wire logic signed [31:0] stored_coordinate_target_rd,
   // Axis parameters
   output logic signed [31:0] target_pos,
   output logic signed [31:0] target_vel,
   output logic vel_mode,
   output logic vel_dir_left,
   output logic move_active,
   output logic move_start,
   output logic move_dir_down
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Frame assembly
   // ----------------------------------------------------------------
   logic [3:0] byte_cnt;
   logic [7:0] f_op, f_typ, f_bank;
   logic [31:0] f_value;
   logic take;

   assign frame_ready = ce;

   always_ff @(posedge clk) begin
      if (rst) begin
         byte_cnt <= 4'h0;
         f_op <= 8'h00;
         f_typ <= 8'h00;
         f_bank <= 8'h00;
         f_value <= 32'h0000_0000;
         take <= 1'b0;
      end else if (ce) begin
         take <= 1'b0;
         if (frame_valid) begin
            // Target address byte is accepted but not matched here
            unique case (byte_cnt)
               4'h1: f_op <= frame_byte;
               4'h2: f_typ <= frame_byte;
               4'h3: f_bank <= frame_byte;
               4'h4, 4'h5, 4'h6, 4'h7: f_value <= {f_value[23:0], frame_byte};
               default: ;
            endcase
            if (byte_cnt == ccam_pkg::FRAME_LAST) begin
               // Checksum byte closes the frame; checking it lives upstream
               byte_cnt <= 4'h0;
               take <= 1'b1;
            end else begin
               byte_cnt <= byte_cnt + 4'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register and decode
   // ----------------------------------------------------------------
   logic [31:0] ctrl;
   logic standalone;
   logic bus_ack, bus_wr, wr_pc;
   logic is_call, is_ret, is_dj, is_mv, is_rl, is_rr, is_abort;
   logic cond_hold, call_jump, ret_pop, dj_nz, mv_ok;
   logic [3:0] depth;
   logic [31:0] stack [0:7];
   logic [31:0] pc_ret;
   logic signed [31:0] next_target;

   assign standalone = ctrl[ccam_pkg::CTRL_STANDALONE];
   assign is_call = take && f_op == ccam_pkg::OP_COND_CALL;
   assign is_ret = take && f_op == ccam_pkg::OP_SUB_RETURN;
   assign is_dj = take && f_op == ccam_pkg::OP_DEC_JUMP;
   assign is_mv = take && f_op == ccam_pkg::OP_MOVE_ACC;
   assign is_rl = take && f_op == ccam_pkg::OP_ROT_L_ACC;
   assign is_rr = take && f_op == ccam_pkg::OP_ROT_R_ACC;
   assign is_abort = take && (f_op == ccam_pkg::OP_MOTOR_STOP || f_op == ccam_pkg::OP_ROT_L ||
                              f_op == ccam_pkg::OP_ROT_R || is_rl || is_rr);

   function automatic logic cond_met(input logic [7:0] t, input ccam_pkg::ccam_cmpf_t c,
                                     input ccam_pkg::ccam_errf_t e);
      case (t)
         ccam_pkg::COND_ZE: cond_met = c.zero;
         ccam_pkg::COND_NZ: cond_met = !c.zero;
         ccam_pkg::COND_EQ: cond_met = c.eq;
         ccam_pkg::COND_NE: cond_met = !c.eq;
         ccam_pkg::COND_GT: cond_met = c.gt;
         ccam_pkg::COND_GE: cond_met = c.gt || c.eq;
         ccam_pkg::COND_LT: cond_met = c.lt;
         ccam_pkg::COND_LE: cond_met = c.lt || c.eq;
         ccam_pkg::COND_ETO: cond_met = e.timeout;
         ccam_pkg::COND_EAL: cond_met = e.ext_alarm;
         ccam_pkg::COND_EDV: cond_met = e.deviation;
         ccam_pkg::COND_EPO: cond_met = e.position;
         default: cond_met = 1'b0;
      endcase
   endfunction

   assign cond_hold = cond_met(f_typ, cmp_flags, err_flags);
   // Direct mode never calls: the stack belongs to the stored program
   assign call_jump = is_call && standalone && cond_hold && depth < ccam_pkg::STACK_DEPTH;
   assign ret_pop = is_ret && standalone && depth != 4'h0;
   assign pc_ret = pc + 32'h0000_0001;

   assign var_idx = f_typ;
   assign var_wr_en = is_dj;
   assign var_wr_data = var_rd - 32'h0000_0001;
   assign dj_nz = var_wr_data != 32'h0000_0000;

   // ----------------------------------------------------------------
   // Program counter and return stack
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pc <= 32'h0000_0000;
      end else if (ce) begin
         if (wr_pc) begin
            pc <= avs_writedata;
         end else if (take && standalone) begin
            if (call_jump || (is_dj && dj_nz)) begin
               pc <= f_value;
            end else if (ret_pop) begin
               pc <= stack[3'(depth - 4'h1)];
            end else begin
               pc <= pc_ret;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         depth <= 4'h0;
      end else if (ce) begin
         if (call_jump) begin
            stack[depth[2:0]] <= pc_ret;
            depth <= depth + 4'h1;
         end else if (ret_pop) begin
            depth <= depth - 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Axis parameters
   // ----------------------------------------------------------------
   assign stored_coordinate_target_idx = f_bank;
   assign mv_ok = f_typ == ccam_pkg::MOVE_ABS || f_typ == ccam_pkg::MOVE_REL ||
                  f_typ == ccam_pkg::MOVE_STORED_COORDINATE_TARGET;

   always_comb begin
      next_target = accum;
      if (f_typ == ccam_pkg::MOVE_REL) begin
         next_target = actual_pos + accum;
      end else if (f_typ == ccam_pkg::MOVE_STORED_COORDINATE_TARGET) begin
         next_target = stored_coordinate_target_rd;
      end
   end

   // Only the target is written; ramp limits stay as software left them
   always_ff @(posedge clk) begin
      if (rst) begin
         target_pos <= 32'sh0000_0000;
         move_active <= 1'b0;
         move_start <= 1'b0;
         move_dir_down <= 1'b0;
      end else if (ce) begin
         move_start <= 1'b0;
         if (is_mv && mv_ok) begin
            target_pos <= next_target;
            move_active <= 1'b1;
            move_start <= 1'b1;
            // Sign of the wrapped difference picks the shorter way round
            move_dir_down <= 1'((next_target - actual_pos) >>> 31);
         end else if (is_abort) begin
            move_active <= 1'b0;
         end else if (move_active && actual_pos == target_pos) begin
            move_active <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         target_vel <= 32'sh0000_0000;
         vel_mode <= 1'b0;
         vel_dir_left <= 1'b0;
      end else if (ce) begin
         if (is_rl || is_rr) begin
            vel_mode <= 1'b1;
            target_vel <= accum;
            vel_dir_left <= is_rl;
         end else if (is_mv && mv_ok) begin
            vel_mode <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Reply in direct mode
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         reply_valid <= 1'b0;
         reply <= '0;
      end else if (ce) begin
         reply_valid <= take && !standalone;
         if (take) begin
            reply.op <= f_op;
            reply.value <= 32'h0000_0000;
            reply.status <= (is_call || (is_mv && !mv_ok)) ? ccam_pkg::STATUS_REFUSED
                                                           : ccam_pkg::STATUS_OK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Avalon-MM slave, one wait state
   // ----------------------------------------------------------------
   assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
   assign bus_wr = avs_write && bus_ack && ce;
   assign wr_pc = bus_wr && avs_address == ccam_pkg::REG_PC;

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_ack <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else if (ce) begin
         bus_ack <= (avs_read || avs_write) && !bus_ack;
         if (avs_read && !bus_ack) begin
            unique case (avs_address)
               ccam_pkg::REG_CTRL: avs_readdata <= ctrl;
               ccam_pkg::REG_STATUS: avs_readdata <= {26'h0, move_active, vel_mode, depth};
               ccam_pkg::REG_PC: avs_readdata <= pc;
               ccam_pkg::REG_TARGET_POS: avs_readdata <= target_pos;
               ccam_pkg::REG_TARGET_VEL: avs_readdata <= target_vel;
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= ccam_pkg::CTRL_RESET;
      end else if (bus_wr && avs_address == ccam_pkg::REG_CTRL) begin
         ctrl <= {31'h0, avs_writedata[ccam_pkg::CTRL_STANDALONE]};
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   sequence s_call_ready;
      is_call && standalone && cond_hold && !wr_pc;
   endsequence

   sequence s_pc_next;
      pc == $past(pc_ret);
   endsequence

   chk_call_push_jump: assert property (s_call_ready ##0 depth < ccam_pkg::STACK_DEPTH |=>
      pc == $past(f_value) && depth == $past(depth) + 4'h1)
      else $error("taken call did not push and jump");

   chk_call_skip: assert property (is_call && standalone && !cond_hold && !wr_pc |=>
      s_pc_next ##0 depth == $past(depth))
      else $error("untaken call changed stack or pc");

   chk_stack_bound: assert property (depth <= ccam_pkg::STACK_DEPTH)
      else $error("return stack overflow");

   chk_call_full: assert property (s_call_ready ##0 depth == ccam_pkg::STACK_DEPTH |=>
      s_pc_next ##0 depth == ccam_pkg::STACK_DEPTH)
      else $error("call on full stack not ignored");

   chk_call_direct: assert property (is_call && !standalone |=>
      depth == $past(depth) && reply.status == ccam_pkg::STATUS_REFUSED)
      else $error("direct mode call was executed");

   chk_move_target: assert property (is_mv && f_typ == ccam_pkg::MOVE_ABS |=>
      target_pos == $past(accum) && !vel_mode && move_active)
      else $error("absolute move target wrong");

   chk_move_rel: assert property (is_mv && f_typ == ccam_pkg::MOVE_REL |=>
      target_pos == $past(actual_pos) + $past(accum))
      else $error("relative move target wrong");

   chk_rot_left: assert property (is_rl |=>
      vel_mode && vel_dir_left && target_vel == $past(accum) && !move_active)
      else $error("rotate left did not set velocity mode");

   chk_reply_ok: assert property ((is_rl || is_rr || (is_mv && mv_ok)) && !standalone |=>
      reply_valid && reply.status == ccam_pkg::STATUS_OK)
      else $error("move or rotate reply not ok");

   chk_abort_move: assert property (is_abort && !(is_mv && mv_ok) |=> !move_active)
      else $error("abort did not end positioning");

   chk_dec_jump: assert property (is_dj && dj_nz && standalone && !wr_pc |=>
      pc == $past(f_value))
      else $error("decrement jump missed");
endmodule

// ==== rtl/ccam_pkg.sv ====
// Constants and carrier types for the accumulator motion and call interpreter
package ccam_pkg;
   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_COND_CALL = 8'h15;
   localparam logic [7:0] OP_DEC_JUMP = 8'h31;
   localparam logic [7:0] OP_MOVE_ACC = 8'h2e;
   localparam logic [7:0] OP_ROT_L_ACC = 8'h32;
   localparam logic [7:0] OP_ROT_R_ACC = 8'h33;
   localparam logic [7:0] OP_SUB_RETURN = 8'hf0;
   localparam logic [7:0] OP_MOTOR_STOP = 8'hf1;
   localparam logic [7:0] OP_ROT_L = 8'hf2;
   localparam logic [7:0] OP_ROT_R = 8'hf3;
   // ----------------------------------------------------------------
   // Type field codes
   // ----------------------------------------------------------------
   localparam logic [7:0] MOVE_ABS = 8'h00;
   localparam logic [7:0] MOVE_REL = 8'h01;
   localparam logic [7:0] MOVE_STORED_COORDINATE_TARGET = 8'h02;
   localparam logic [7:0] COND_ZE = 8'h00;
   localparam logic [7:0] COND_NZ = 8'h01;
   localparam logic [7:0] COND_EQ = 8'h02;
   localparam logic [7:0] COND_NE = 8'h03;
   localparam logic [7:0] COND_GT = 8'h04;
   localparam logic [7:0] COND_GE = 8'h05;
   localparam logic [7:0] COND_LT = 8'h06;
   localparam logic [7:0] COND_LE = 8'h07;
   localparam logic [7:0] COND_ETO = 8'h08;
   localparam logic [7:0] COND_EAL = 8'h09;
   localparam logic [7:0] COND_EDV = 8'h0a;
   localparam logic [7:0] COND_EPO = 8'h0b;
   // ----------------------------------------------------------------
   // Stack, frame, reply
   // ----------------------------------------------------------------
   localparam logic [3:0] STACK_DEPTH = 4'h8;
   localparam logic [3:0] FRAME_LAST = 4'h8;
   localparam logic [7:0] STATUS_OK = 8'h64;
   localparam logic [7:0] STATUS_REFUSED = 8'h02;
   // ----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_PC = 5'h08;
   localparam logic [4:0] REG_TARGET_POS = 5'h0c;
   localparam logic [4:0] REG_TARGET_VEL = 5'h10;
   localparam int CTRL_STANDALONE = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [7:0] op;
      logic [7:0] typ;
      logic [7:0] bank;
      logic [31:0] value;
   } ccam_cmd_t;

   typedef struct packed {
      logic zero;
      logic eq;
      logic gt;
      logic lt;
   } ccam_cmpf_t;

   typedef struct packed {
      logic timeout;
      logic ext_alarm;
      logic deviation;
      logic position;
   } ccam_errf_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] op;
      logic [31:0] value;
   } ccam_reply_t;
endpackage

// ==== verif/ccam_host.sv ====
// Host model that streams command frames into the interpreter
`timescale 1ns/1ps
module ccam_host (
   // Clock
   input wire logic clk,
   // Frame stream
   output logic frame_valid,
   output logic [7:0] frame_byte
);
   initial begin
      frame_valid = 1'b0;
      frame_byte = 8'h00;
   end

   // ----------------------------------------------------------------
   // Frame sender
   // ----------------------------------------------------------------
   task automatic send(input ccam_pkg::ccam_cmd_t c);
      logic [7:0] b [9];
      logic [7:0] sum;
      b[0] = 8'h01;
      {b[1], b[2], b[3], b[4], b[5], b[6], b[7]} = c;
      sum = 8'h00;
      for (int i = 0; i < 8; i++) begin
         sum = sum + b[i];
      end
      b[8] = sum;
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         frame_valid <= 1'b1;
         frame_byte <= b[i];
      end
      @(posedge clk);
      frame_valid <= 1'b0;
      // Released line shows the inverse so a stale byte cannot pass for data
      frame_byte <= ~b[8];
   endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the call stack, accumulator move and rotate slice
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] var_rd = 32'h0;
   logic signed [31:0] accum = 32'h0;
   logic signed [31:0] actual_pos = 32'h0;
   logic signed [31:0] stored_coordinate_target_rd = 32'h0;
   ccam_pkg::ccam_cmpf_t cmp_flags = 4'h0;
   ccam_pkg::ccam_errf_t err_flags = 4'h0;
   logic [31:0] avs_readdata, pc, var_wr_data, q;
   logic avs_waitrequest, frame_valid, frame_ready, reply_valid, var_wr_en;
   logic vel_mode, vel_dir_left, move_active, move_start, move_dir_down;
   logic [7:0] frame_byte, var_idx, stored_coordinate_target_idx, typ, bk;
   logic signed [31:0] target_pos, target_vel, m_tp, diff;
   ccam_pkg::ccam_reply_t reply;
   logic [40:0] side;
   logic [7:0] ab [4] = '{8'hf1, 8'hf2, 8'hf3, 8'h32};
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   int seed, m_pc;
   int stack[$];

   always #50 clk = ~clk;

   ccam_core DUT (.clk, .rst, .ce(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .frame_valid, .frame_byte, .frame_ready, .pc,
      .reply_valid, .reply, .accum, .cmp_flags, .err_flags, .actual_pos, .var_idx, .var_rd,
      .var_wr_en, .var_wr_data, .stored_coordinate_target_idx, .stored_coordinate_target_rd, .target_pos, .target_vel, .vel_mode,
      .vel_dir_left, .move_active, .move_start, .move_dir_down);

   ccam_host host (.clk, .frame_valid, .frame_byte);

   // ----------------------------------------------------------------
   // Shared tasks and reference model
   // ----------------------------------------------------------------
   task automatic chk(input logic [47:0] s, input logic [47:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic end_of_test();
      $display("Counts: checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      // Waitrequest is sampled at the edge itself; read data is taken at that same edge
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // Combinational side ports are only valid in the execute cycle
   task automatic run(input ccam_pkg::ccam_cmd_t c);
      host.send(c);
      #1;
      side = {var_wr_en, var_idx, var_wr_data};
      @(posedge clk);
      #1;
   endtask

   function automatic logic cond(input logic [7:0] t);
      case (t)
         8'd0: return cmp_flags.zero;
         8'd1: return !cmp_flags.zero;
         8'd2: return cmp_flags.eq;
         8'd3: return !cmp_flags.eq;
         8'd4: return cmp_flags.gt;
         8'd5: return cmp_flags.gt | cmp_flags.eq;
         8'd6: return cmp_flags.lt;
         8'd7: return cmp_flags.lt | cmp_flags.eq;
         8'd8: return err_flags.timeout;
         8'd9: return err_flags.ext_alarm;
         8'd10: return err_flags.deviation;
         8'd11: return err_flags.position;
         default: return 1'b0;
      endcase
   endfunction

   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         fail_count++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h4c24;
      m_tp = 32'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk({pc, reply_valid, move_active, avs_waitrequest, frame_ready}, 36'h1);
      bus(1'b0, ccam_pkg::REG_CTRL, 32'h0, q);
      chk(q, ccam_pkg::CTRL_RESET);
      bus(1'b1, 5'h14, 32'hffff_ffff, q);
      bus(1'b0, 5'h14, 32'h0, q);
      chk(q, 32'h0);
      // Direct mode moves, last pass straddles the 32-bit wrap
      for (int t = 0; t < 5; t++) begin
         @(posedge clk);
         accum <= (t == 4) ? 32'h7fff_ffff : $random(seed);
         actual_pos <= (t == 4) ? 32'h8000_0000 : $random(seed);
         stored_coordinate_target_rd <= $random(seed);
         typ = (t == 4) ? 8'h00 : 8'(t);
         bk = 8'($random(seed));
         run({ccam_pkg::OP_MOVE_ACC, typ, bk, 32'($random(seed))});
         if (typ == 8'h00) m_tp = accum;
         else if (typ == 8'h01) m_tp = actual_pos + accum;
         else if (typ == 8'h02) m_tp = stored_coordinate_target_rd;
         diff = m_tp - actual_pos;
         chk(reply_valid, 1'b1);
         chk(reply, {(typ < 8'h03) ? ccam_pkg::STATUS_OK : ccam_pkg::STATUS_REFUSED,
                     ccam_pkg::OP_MOVE_ACC, 32'h0});
         chk(target_pos, m_tp);
         chk(stored_coordinate_target_idx, bk);
         if (typ < 8'h03) chk({move_start, move_active, move_dir_down}, {2'b11, diff[31]});
      end
      bus(1'b1, ccam_pkg::REG_TARGET_POS, 32'hdead_beef, q);
      bus(1'b0, ccam_pkg::REG_TARGET_POS, 32'h0, q);
      chk(q, m_tp);
      @(posedge clk);
      accum <= 32'h1234;
      actual_pos <= 32'h0;
      foreach (ab[i]) begin
         run({ccam_pkg::OP_MOVE_ACC, 16'h0, 32'h0});
         chk(move_active, 1'b1);
         run({ab[i], 8'($random(seed)), 8'($random(seed)), 32'($random(seed))});
         chk(move_active, 1'b0);
      end
      chk({vel_mode, vel_dir_left, target_vel, reply.status}, {2'b11, accum, 8'h64});
      run({ccam_pkg::OP_ROT_R_ACC, 16'h0, 32'h0});
      chk({vel_mode, vel_dir_left, target_vel}, {2'b10, accum});
      // Arrival at the target ends the move without any command
      run({ccam_pkg::OP_MOVE_ACC, 16'h0, 32'h0});
      chk(move_active, 1'b1);
      @(posedge clk);
      actual_pos <= 32'h1234;
      @(posedge clk);
      #1;
      chk(move_active, 1'b0);
      run({ccam_pkg::OP_COND_CALL, ccam_pkg::COND_NZ, 8'h00, 32'h55});
      chk({reply.status, pc}, {ccam_pkg::STATUS_REFUSED, 32'h0});
      // Standalone program: calls of every type, then overflow and unwind
      bus(1'b1, ccam_pkg::REG_CTRL, 32'h1, q);
      bus(1'b1, ccam_pkg::REG_PC, 32'h10, q);
      m_pc = 16;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         cmp_flags <= (i < 26) ? 4'($random(seed)) : 4'h0;
         err_flags <= 4'($random(seed));
         @(posedge clk);
         typ = (i < 26) ? 8'(i % 13) : ccam_pkg::COND_NZ;
         bk = 8'($random(seed));
         run({ccam_pkg::OP_COND_CALL, typ, 8'h00, 24'h0, bk});
         if (cond(typ) && stack.size() < 8) begin
            stack.push_back(m_pc + 1);
            m_pc = bk;
         end else begin
            m_pc++;
         end
         chk({reply_valid, pc}, {1'b0, 32'(m_pc)});
         bus(1'b0, ccam_pkg::REG_STATUS, 32'h0, q);
         chk(q[3:0], stack.size());
      end
      for (int i = 0; i < 9; i++) begin
         run({ccam_pkg::OP_SUB_RETURN, 16'h0, 32'h0});
         if (stack.size() > 0) m_pc = stack.pop_back();
         else m_pc++;
         chk(pc, 32'(m_pc));
      end
      for (int v = 5; v > 0; v = v - 4) begin
         @(posedge clk);
         var_rd <= 32'(v);
         run({ccam_pkg::OP_DEC_JUMP, 8'h2a, 8'h00, 32'h40});
         m_pc = (v > 1) ? 32'h40 : m_pc + 1;
         chk(side, {1'b1, 8'h2a, 32'(v - 1)});
         chk(pc, 32'(m_pc));
      end
      end_of_test();
   end
endmodule
